/* rtl/pulse_train_pwm_profile.sv */
`timescale 1ns/100ps
module pulse_train_pwm_profile #(
	parameter int MS_TICK_CYCLES = pulse_pkg::MS_CYCLES
) (
	input  wire logic                         mclk_i,
	input  wire logic                         reset_n_i,
	input  wire logic [7:0]                   pulse_ctrl_byte_i,
	input  wire logic [15:0]                  period_value_i,
	input  wire logic [15:0]                  width_value_i,
	input  wire logic [31:0]                  count_value_i,
	input  wire logic                         load_pulse_command_i,
	input  wire logic                         tbl_wr_en_i,
	input  wire logic [pulse_pkg::TBL_AW-1:0] tbl_wr_addr_i,
	input  wire logic [7:0]                   tbl_wr_data_i,
	input  wire logic                         output_image_i,
	input  wire logic                         step_error_clr_i,
	input  wire logic                         pipe_overflow_clr_i,
	output logic                              pulse_output_pin_o,
	output logic                              pin_driven_o,
	output logic                              idle_o,
	output logic                              step_error_flag_o,
	output logic                              pipe_overflow_flag_o,
	output logic      [7:0]                   segment_num_o
);

	localparam logic [pulse_pkg::TICK_W-1:0] US_LOAD = pulse_pkg::TICK_W'(pulse_pkg::US_CYCLES - 1);
	localparam logic [pulse_pkg::TICK_W-1:0] MS_LOAD = pulse_pkg::TICK_W'(MS_TICK_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////////
	// State

	pulse_pkg::gen_state_e state_reg, state_next;
	logic [7:0]  sh_ctrl_reg,   sh_ctrl_next;
	logic [15:0] sh_period_reg, sh_period_next;
	logic [15:0] sh_width_reg,  sh_width_next;
	logic [31:0] sh_count_reg,  sh_count_next;
	logic        pend_reg,      pend_next;
	logic        ms_reg,        ms_next;
	logic [15:0] period_reg,    period_next;
	logic [15:0] width_reg,     width_next;
	logic [15:0] delta_reg,     delta_next;
	logic [31:0] left_reg,      left_next;
	logic [15:0] phase_reg,     phase_next;
	logic [7:0]  seg_total_reg, seg_total_next;
	logic [7:0]  seg_idx_reg,   seg_idx_next;
	logic [pulse_pkg::TBL_AW-1:0] faddr_reg, faddr_next;
	logic [3:0]  fidx_reg,      fidx_next;
	logic        fph_reg,       fph_next;
	logic        err_reg,       err_next;
	logic        ovf_reg,       ovf_next;
	logic        pin_reg,       pin_next;
	logic [pulse_pkg::TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
	logic        tick;
	logic [7:0]  rd_byte;

	// Merged values seen by a load; update bits pick new or last committed
	logic [7:0]  m_ctrl;
	logic [15:0] m_period;
	logic [15:0] m_width;
	logic [31:0] m_count;
	logic [17:0] sum_period;
	logic        period_end;
	logic        apply;
	logic        gen_level;

	profile_mem u_mem (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.wr_en_i   (tbl_wr_en_i),
		.wr_addr_i (tbl_wr_addr_i),
		.wr_data_i (tbl_wr_data_i),
		.rd_addr_i (faddr_reg),
		.rd_data_o (rd_byte)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Time base divider, one tick enable per us or ms

	always_comb begin
		tick = (tick_cnt_reg == '0);
		if (tick) begin
			tick_cnt_next = ms_reg ? MS_LOAD : US_LOAD;
		end else begin
			tick_cnt_next = tick_cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Generator control

	always_comb begin
		m_ctrl   = pulse_ctrl_byte_i;
		m_period = m_ctrl[pulse_pkg::CTL_UPD_PERIOD] ? period_value_i : sh_period_reg;
		m_width  = m_ctrl[pulse_pkg::CTL_UPD_WIDTH] ? width_value_i : sh_width_reg;
		m_count  = m_ctrl[pulse_pkg::CTL_UPD_COUNT] ? count_value_i : sh_count_reg;
		sum_period = {2'b00, period_reg} + {{2{delta_reg[15]}}, delta_reg};
		period_end = tick && (phase_reg == period_reg - 1'b1);
		apply = 1'b0;
		state_next = state_reg;
		sh_ctrl_next = sh_ctrl_reg;
		sh_period_next = sh_period_reg;
		sh_width_next = sh_width_reg;
		sh_count_next = sh_count_reg;
		pend_next = pend_reg;
		ms_next = ms_reg;
		period_next = period_reg;
		width_next = width_reg;
		delta_next = delta_reg;
		left_next = left_reg;
		phase_next = phase_reg;
		seg_total_next = seg_total_reg;
		seg_idx_next = seg_idx_reg;
		faddr_next = faddr_reg;
		fidx_next = fidx_reg;
		fph_next = fph_reg;
		err_next = err_reg && !step_error_clr_i;
		ovf_next = ovf_reg && !pipe_overflow_clr_i;

		// Running phase counter, one step per time base tick
		if ((state_reg == pulse_pkg::ST_PULSE || state_reg == pulse_pkg::ST_PWM) && tick) begin
			phase_next = period_end ? 16'h0000 : phase_reg + 1'b1;
		end

		// End of a period
		if (period_end && state_reg == pulse_pkg::ST_PWM && pend_reg) begin
			apply = 1'b1;
		end else if (period_end && state_reg == pulse_pkg::ST_PULSE) begin
			left_next = left_reg - 1'b1;
			if (left_reg == 32'h0000_0001) begin
				if (sh_ctrl_reg[pulse_pkg::CTL_MULTI] && seg_idx_reg < seg_total_reg) begin
					state_next = pulse_pkg::ST_FETCH;
					fidx_next = pulse_pkg::FLD_FIRST_SEG;
					fph_next = 1'b0;
				end else if (pend_reg) begin
					apply = 1'b1;
				end else begin
					state_next = pulse_pkg::ST_IDLE;
				end
			end else if (sum_period[17:16] != 2'b00 || sum_period[15:0] < pulse_pkg::PERIOD_MIN) begin
				state_next = pulse_pkg::ST_IDLE;
				err_next = 1'b1;
				pend_next = 1'b0;
			end else begin
				// final period reached by repeated steps only
				period_next = sum_period[15:0];
			end
		end

		// Segment fetch: phase 0 addresses, phase 1 captures the byte
		if (state_reg == pulse_pkg::ST_FETCH) begin
			fph_next = !fph_reg;
			if (fph_reg) begin
				faddr_next = faddr_reg + 1'b1;
				fidx_next = fidx_reg + 1'b1;
				if (fidx_reg == pulse_pkg::FLD_COUNT_BYTE) begin
					seg_total_next = rd_byte;
					// zero segments is nothing to run
					if (rd_byte == 8'h00) begin
						state_next = pulse_pkg::ST_IDLE;
					end
				end else if (fidx_reg <= pulse_pkg::FLD_PER_LO) begin
					period_next = {period_reg[7:0], rd_byte};
				end else if (fidx_reg <= pulse_pkg::FLD_DELTA_LO) begin
					delta_next = {delta_reg[7:0], rd_byte};
				end else begin
					left_next = {left_reg[23:0], rd_byte};
				end
				if (fidx_reg == pulse_pkg::FLD_LAST) begin
					seg_idx_next = seg_idx_reg + 1'b1;
					fidx_next = pulse_pkg::FLD_FIRST_SEG;
					phase_next = 16'h0000;
					if ({left_reg[23:0], rd_byte} != 32'h0000_0000) begin
						state_next = pulse_pkg::ST_PULSE;
					end else if (seg_idx_reg + 1'b1 >= seg_total_reg) begin
						state_next = pulse_pkg::ST_IDLE;
					end
				end
			end
		end

		// Load command
		if (load_pulse_command_i) begin
			if (!m_ctrl[pulse_pkg::CTL_ENABLE]) begin
				state_next = pulse_pkg::ST_IDLE;
				pend_next = 1'b0;
				sh_ctrl_next = m_ctrl;
			end else if (state_reg == pulse_pkg::ST_IDLE) begin
				apply = 1'b1;
			end else if (pend_reg && state_reg != pulse_pkg::ST_PWM) begin
				ovf_next = 1'b1;
			end else if (state_reg == pulse_pkg::ST_PWM && m_ctrl[pulse_pkg::CTL_PWM]
					&& !m_ctrl[pulse_pkg::CTL_SYNC]) begin
				apply = 1'b1;
			end else begin
				// held until the running train allows it
				pend_next = 1'b1;
				sh_ctrl_next = m_ctrl;
				sh_period_next = m_period;
				sh_width_next = m_width;
				sh_count_next = m_count;
			end
		end

		// committed values become the running ones
		if (apply) begin
			pend_next = 1'b0;
			phase_next = 16'h0000;
			if (load_pulse_command_i) begin
				sh_ctrl_next = m_ctrl;
				sh_period_next = m_period;
				sh_width_next = m_width;
				sh_count_next = m_count;
			end
			ms_next = sh_ctrl_next[pulse_pkg::CTL_TIMEBASE];
			period_next = sh_period_next;
			width_next = sh_width_next;
			delta_next = 16'h0000;
			left_next = sh_count_next;
			seg_idx_next = 8'h00;
			if (sh_ctrl_next[pulse_pkg::CTL_PWM]) begin
				state_next = pulse_pkg::ST_PWM;
			end else if (sh_ctrl_next[pulse_pkg::CTL_MULTI]) begin
				state_next = pulse_pkg::ST_FETCH;
				faddr_next = pulse_pkg::TBL_BASE;
				fidx_next = pulse_pkg::FLD_COUNT_BYTE;
				fph_next = 1'b0;
			end else if (sh_count_next != 32'h0000_0000) begin
				state_next = pulse_pkg::ST_PULSE;
			end else begin
				state_next = pulse_pkg::ST_IDLE;
			end
		end

		// Square wave for trains, width-limited high time for PWM
		if (state_reg == pulse_pkg::ST_PWM) begin
			gen_level = phase_reg < width_reg;
		end else begin
			gen_level = (state_reg == pulse_pkg::ST_PULSE) && (phase_reg < {1'b0, period_reg[15:1]});
		end
		// pin falls back to the image when idle; held low during fetch
		pin_next = (state_reg == pulse_pkg::ST_IDLE) ? output_image_i : gen_level;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg     <= pulse_pkg::ST_IDLE;
			sh_ctrl_reg   <= pulse_pkg::CTL_RESET;
			sh_period_reg <= 16'h0000;
			sh_width_reg  <= 16'h0000;
			sh_count_reg  <= 32'h0000_0000;
			pend_reg      <= 1'b0;
			ms_reg        <= 1'b0;
			period_reg    <= 16'h0000;
			width_reg     <= 16'h0000;
			delta_reg     <= 16'h0000;
			left_reg      <= 32'h0000_0000;
			phase_reg     <= 16'h0000;
			seg_total_reg <= 8'h00;
			seg_idx_reg   <= 8'h00;
			faddr_reg     <= pulse_pkg::TBL_BASE;
			fidx_reg      <= 4'h0;
			fph_reg       <= 1'b0;
			err_reg       <= 1'b0;
			ovf_reg       <= 1'b0;
			pin_reg       <= 1'b0;
		end else begin
			state_reg     <= state_next;
			sh_ctrl_reg   <= sh_ctrl_next;
			sh_period_reg <= sh_period_next;
			sh_width_reg  <= sh_width_next;
			sh_count_reg  <= sh_count_next;
			pend_reg      <= pend_next;
			ms_reg        <= ms_next;
			period_reg    <= period_next;
			width_reg     <= width_next;
			delta_reg     <= delta_next;
			left_reg      <= left_next;
			phase_reg     <= phase_next;
			seg_total_reg <= seg_total_next;
			seg_idx_reg   <= seg_idx_next;
			faddr_reg     <= faddr_next;
			fidx_reg      <= fidx_next;
			fph_reg       <= fph_next;
			err_reg       <= err_next;
			ovf_reg       <= ovf_next;
			pin_reg       <= pin_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign pulse_output_pin_o   = pin_reg;
	assign pin_driven_o         = (state_reg != pulse_pkg::ST_IDLE);
	assign idle_o               = (state_reg == pulse_pkg::ST_IDLE);
	assign step_error_flag_o    = err_reg;
	assign pipe_overflow_flag_o = ovf_reg;
	assign segment_num_o        = seg_idx_reg;

endmodule : pulse_train_pwm_profile

/* rtl/pulse_pkg.sv */
package pulse_pkg;

	// Clock and time base
	localparam int CLK_PERIOD_NS = 8;
	localparam int US_NS         = 1000;
	localparam int MS_NS         = 1000000;
	localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int TICK_W        = 17;

	// Control byte fields
	localparam int CTL_UPD_PERIOD = 0;
	localparam int CTL_UPD_WIDTH  = 1;
	localparam int CTL_UPD_COUNT  = 2;
	localparam int CTL_TIMEBASE   = 3;
	localparam int CTL_SYNC       = 4;
	localparam int CTL_MULTI      = 5;
	localparam int CTL_PWM        = 6;
	localparam int CTL_ENABLE     = 7;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// Profile table layout
	localparam int TBL_AW         = 11;
	localparam int TBL_DEPTH      = 2048;
	localparam logic [TBL_AW-1:0] TBL_BASE = 11'h000;
	localparam logic [3:0] FLD_COUNT_BYTE = 4'h0;
	localparam logic [3:0] FLD_PER_LO     = 4'h2;
	localparam logic [3:0] FLD_DELTA_LO   = 4'h4;
	localparam logic [3:0] FLD_LAST       = 4'h8;
	localparam logic [3:0] FLD_FIRST_SEG  = 4'h1;

	// Legal period range
	localparam logic [15:0] PERIOD_MIN = 16'h0002;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_PULSE = 4'b0100,
		ST_PWM   = 4'b1000
	} gen_state_e;

endpackage : pulse_pkg

/* rtl/profile_mem.sv */
`timescale 1ns/100ps
// Byte-wide profile table, written by firmware, read by the segment fetcher
module profile_mem (
	input  wire logic                           mclk_i,
	input  wire logic                           reset_n_i,
	input  wire logic                           wr_en_i,
	input  wire logic [pulse_pkg::TBL_AW-1:0]   wr_addr_i,
	input  wire logic [7:0]                     wr_data_i,
	input  wire logic [pulse_pkg::TBL_AW-1:0]   rd_addr_i,
	output logic      [7:0]                     rd_data_o
);

	logic [7:0] mem_array [0:pulse_pkg::TBL_DEPTH-1];

	// Array has no reset so it maps onto block memory
	always_ff @(posedge mclk_i) begin
		if (wr_en_i) begin
			mem_array[wr_addr_i] <= wr_data_i;
		end
	end

	// Registered read, one cycle of latency
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= 8'h00;
		end else begin
			rd_data_o <= mem_array[rd_addr_i];
		end
	end

endmodule : profile_mem

/* bench/pulse_train_pwm_profile_assertions.sv */
`timescale 1ns/100ps
// Port-level checks for the pulse generator
module pulse_train_pwm_profile_assertions #(
	parameter int MS_TICK_CYCLES = pulse_pkg::MS_CYCLES
) (
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic [7:0]  pulse_ctrl_byte_i,
	input  wire logic        load_pulse_command_i,
	input  wire logic        output_image_i,
	input  wire logic        step_error_clr_i,
	input  wire logic        pipe_overflow_clr_i,
	input  wire logic        pulse_output_pin_o,
	input  wire logic        pin_driven_o,
	input  wire logic        idle_o,
	input  wire logic        step_error_flag_o,
	input  wire logic        pipe_overflow_flag_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	a_owner_matches_idle: assert property (pin_driven_o == !idle_o)
		else $error("pin owner flag disagrees with idle");
	a_idle_pin_image: assert property ($past(idle_o) |-> pulse_output_pin_o == $past(output_image_i))
		else $error("idle pin does not follow the image");
	a_load_starts_run: assert property (idle_o && load_pulse_command_i && pulse_ctrl_byte_i[7]
		&& pulse_ctrl_byte_i[6] && pulse_ctrl_byte_i[0] |=> !idle_o)
		else $error("enabled load did not start");
	a_disable_stops: assert property (load_pulse_command_i && !pulse_ctrl_byte_i[7] |=> idle_o)
		else $error("disabling load did not stop");
	a_idle_holds: assert property (idle_o && !load_pulse_command_i |=> idle_o)
		else $error("started without a load");
	a_err_sticky: assert property (step_error_flag_o && !step_error_clr_i |=> step_error_flag_o)
		else $error("step error dropped without clear");
	a_err_goes_idle: assert property ($rose(step_error_flag_o) |-> ##[0:1] idle_o)
		else $error("step error without stop");
	a_ovf_sticky: assert property (pipe_overflow_flag_o && !pipe_overflow_clr_i
		|=> pipe_overflow_flag_o)
		else $error("overflow dropped without clear");
	// overflow needs a load while busy
	a_ovf_cause: assert property ($rose(pipe_overflow_flag_o)
		|-> $past(load_pulse_command_i) && !$past(idle_o))
		else $error("overflow without a busy load");
endmodule : pulse_train_pwm_profile_assertions

bind pulse_train_pwm_profile pulse_train_pwm_profile_assertions #(
	.MS_TICK_CYCLES(MS_TICK_CYCLES)
) chk_u (
	.mclk_i, .reset_n_i, .pulse_ctrl_byte_i, .load_pulse_command_i, .output_image_i,
	.step_error_clr_i, .pipe_overflow_clr_i, .pulse_output_pin_o, .pin_driven_o, .idle_o,
	.step_error_flag_o, .pipe_overflow_flag_o
);

/* bench/pulse_fw_model.sv */
`timescale 1ns/100ps
// Firmware stand-in; every change lands on a falling edge
module pulse_fw_model (
	input  wire logic                         mclk_i,
	output logic      [7:0]                   ctrl_o,
	output logic      [15:0]                  period_o,
	output logic      [15:0]                  width_o,
	output logic      [31:0]                  count_o,
	output logic                              load_o,
	output logic                              we_o,
	output logic      [pulse_pkg::TBL_AW-1:0] addr_o,
	output logic      [7:0]                   data_o
);
	// Quiet outputs at time zero
	initial begin
		{ctrl_o, period_o, width_o, count_o, load_o, we_o, addr_o, data_o} = '0;
	end

	// values settle a cycle before the load
	task automatic issue(input logic [7:0] c, input logic [15:0] p, w,
		input logic [31:0] n, input logic go);
		@(negedge mclk_i);
		ctrl_o = c;
		period_o = p;
		width_o = w;
		count_o = n;
		@(negedge mclk_i);
		load_o = go;
		@(negedge mclk_i);
		load_o = 1'b0;
	endtask : issue

	// One table byte per write cycle
	task automatic put(input int a, input logic [7:0] d);
		@(negedge mclk_i);
		we_o = 1'b1;
		addr_o = a[pulse_pkg::TBL_AW-1:0];
		data_o = d;
		@(negedge mclk_i);
		we_o = 1'b0;
	endtask : put

	// entry laid out high byte first
	// period and delta as whole ticks
	task automatic seg(input int i, input logic [15:0] p, d, input logic [31:0] n);
		logic [63:0] v;
		v = {p, d, n};
		for (int k = 0; k < 8; k++) begin
			put(1 + 8 * i + k, v[63 - 8 * k -: 8]);
		end
	endtask : seg
endmodule : pulse_fw_model

/* bench/pulse_train_pwm_profile_bench.sv */
`timescale 1ns/100ps
module pulse_train_pwm_profile_bench;
	localparam int TK = 10;
	localparam int US = pulse_pkg::US_CYCLES;
	typedef struct {logic [7:0] c; logic [15:0] p, w, ep;} row_s;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic image = 1'b0;
	logic eclr = 1'b0;
	logic oclr = 1'b0;
	logic [7:0] ctrl, segn, sg;
	logic [15:0] pv, wv;
	logic [31:0] cv;
	logic load, we, pin, drv, idle, err, ovf;
	logic [pulse_pkg::TBL_AW-1:0] wa;
	logic [7:0] wd;
	int fails, checks_done, cyc, hi, per, tk;
	row_s rows [4] = '{'{8'hDB, 4, 1, 4}, '{8'hDA, 9, 3, 4}, '{8'hD3, 3, 1, 3}, '{8'hD2, 7, 2, 3}};
	logic [7:0] exp_hi [4] = '{2, 3, 4, 3};
	logic [7:0] exp_sg [4] = '{1, 1, 1, 2};

	// Short ms tick keeps runs brief
	always #4 mclk_i = ~mclk_i;

	pulse_fw_model fw (.mclk_i, .ctrl_o(ctrl), .period_o(pv), .width_o(wv), .count_o(cv),
		.load_o(load), .we_o(we), .addr_o(wa), .data_o(wd));

	pulse_train_pwm_profile #(.MS_TICK_CYCLES(TK)) dut_u (
		.mclk_i, .reset_n_i, .pulse_ctrl_byte_i(ctrl), .period_value_i(pv), .width_value_i(wv),
		.count_value_i(cv), .load_pulse_command_i(load), .tbl_wr_en_i(we), .tbl_wr_addr_i(wa),
		.tbl_wr_data_i(wd), .output_image_i(image), .step_error_clr_i(eclr),
		.pipe_overflow_clr_i(oclr), .pulse_output_pin_o(pin), .pin_driven_o(drv),
		.idle_o(idle), .step_error_flag_o(err), .pipe_overflow_flag_o(ovf),
		.segment_num_o(segn));

	task automatic check(input string name, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
		end
	endtask : check

	// Times one pulse, rounded up to ticks so an early first tick is tolerated
	task automatic grab();
		int h, l;
		h = 0;
		l = 0;
		while (pin !== 1'b1 && l < 3000) begin @(negedge mclk_i); l++; end
		l = 0;
		while (pin === 1'b1) begin @(negedge mclk_i); h++; end
		sg = segn;
		while (pin !== 1'b1 && l < 3000) begin @(negedge mclk_i); l++; end
		hi = (h + tk - 1) / tk;
		per = (h + l + tk - 1) / tk;
	endtask : grab

	task automatic stop();
		fw.issue(8'h00, 0, 0, 0, 1'b1);
		@(negedge mclk_i);
		check("idle after stop", idle, 1'b1);
	endtask : stop

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// Cycle ceiling cuts a hang short
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i) reset_n_i = 1'b1;
		check("reset state", {idle, drv, err, ovf, segn}, 12'h800);
		// PWM rows; sync updates land at period end, so the third pulse is judged
		foreach (rows[i]) begin
			tk = rows[i].c[3] ? TK : US;
			fw.issue(rows[i].c, rows[i].p, rows[i].w, 0, 1'b1);
			repeat (3) grab();
			check("pwm high", hi, rows[i].w);
			check("pwm period", per, rows[i].ep);
		end
		fw.issue(8'hD2, 16'h0009, 16'h0001, 0, 1'b0);
		repeat (2) grab();
		check("width without load", hi, 2);
		// Async PWM update; the third pulse is judged since the old tick may still be running
		tk = TK;
		fw.issue(8'hCB, 16'h0005, 16'h0002, 0, 1'b1);
		repeat (3) grab();
		check("async pwm high", hi, 2);
		check("async pwm period", per, 5);
		stop();
		// Empty profile never starts
		tk = TK;
		fw.put(0, 8'h00);
		fw.issue(8'hA8, 0, 0, 0, 1'b1);
		// Count byte needs two fetch clocks before the zero is seen
		repeat (3) @(negedge mclk_i);
		check("empty profile", idle, 1'b1);
		// Two segments: ramp 4,6,8 then run at 6
		fw.put(0, 8'h02);
		fw.seg(0, 16'h0004, 16'h0002, 3);
		fw.seg(1, 16'h0006, 16'h0000, 1);
		fw.issue(8'hA8, 0, 0, 0, 1'b1);
		for (int k = 0; k < 4; k++) begin
			grab();
			check("segment high", hi, exp_hi[k]);
			check("segment number", sg, exp_sg[k]);
		end
		check("profile done", idle, 1'b1);
		// Delta drives period below two
		fw.put(0, 8'h01);
		fw.seg(0, 16'h0004, 16'hFFFD, 3);
		fw.issue(8'hA8, 0, 0, 0, 1'b1);
		grab();
		check("first pulse", hi, 2);
		check("step error", {err, idle}, 2'b11);
		image = 1'b1;
		repeat (2) @(negedge mclk_i);
		check("pin to image", pin, 1'b1);
		eclr = 1'b1;
		@(negedge mclk_i) eclr = 1'b0;
		check("error cleared", err, 1'b0);
		image = 1'b0;
		// Running train, pending slot filled, then one load too many
		repeat (3) fw.issue(8'h8D, 16'h0004, 0, 5, 1'b1);
		@(negedge mclk_i);
		check("overflow", ovf, 1'b1);
		repeat (20) @(negedge mclk_i);
		check("overflow sticky", ovf, 1'b1);
		oclr = 1'b1;
		@(negedge mclk_i) oclr = 1'b0;
		check("overflow cleared", ovf, 1'b0);
		stop();
		// Reset in mid-run drops the train and hands the pin back
		fw.issue(8'h8D, 16'h0004, 0, 5, 1'b1);
		repeat (5) @(negedge mclk_i);
		reset_n_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		check("reset mid-run", {idle, drv, pin, segn}, 11'h400);
		reset_n_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		check("image after reset", {idle, pin}, 2'b10);
		tally_and_finish();
	end
endmodule : pulse_train_pwm_profile_bench
